// ### design/acs_pkg.sv
// Shared constants, types and helpers for the converter register bank
// What this block does
// - Latch source bit 0 drives latch pins from the selected setup's latch field.
// - Latch source bit 1 drives latch pins from the configuration latch field.
// - Latch pins update when a command executes; code bit 1 is A0, bit 0 A1.
// - Guard bit frees the first latch pin; its level still follows the source select.
// - Calibration source 0 uses the setup channel, 1 uses the setup pointer.
// - Rate family bit 1 stretches every word period by six fifths.
// - Word-rate codes 0000-0100 and 1000-1100 are decoded, other codes unused.
// - Every word period is a division of the master clock.
// - First continuous result and every single result take longer than one period.
// - Power-down picks standby or sleep by the power-save select bit.
// - Writing reset-system 1 resets the internal state; the next configuration write resumes, whatever its data.
// - Reset-done flag sets when reset-system is written 1, not on pin reset; clears when configuration is read.
// - Input-short bit shorts all input pairs internally.
// - Four 32-bit pair registers hold eight setups, even setup in upper half.
// - Command 0x05 writes one setup pair register with 32 data bits.
// - Channel select codes 00-11 pick physical channels 1 to 4.
// - Gain code is a power of two, 1 at 000 to 64 at 110.
// - Setup latch field sits at 21:20 upper and 5:4 lower.
// - Settle delay waits 1280 or 1536 master clocks by rate family.
// - Calibration pointer codes 00-11 pick channel 1 to 4 registers.
package acs_pkg;
  localparam int CFG_SAVE_SEL = 31;
  localparam int CFG_PWR_DOWN = 30;
  localparam int CFG_SYS_RST = 29;
  localparam int CFG_RST_DONE = 28;
  localparam int CFG_IN_SHORT = 27;
  localparam int CFG_GUARD = 26;
  localparam int CFG_REF_RANGE = 25;
  localparam int CFG_LATCH_HI = 24;
  localparam int CFG_LATCH_LO = 23;
  localparam int CFG_LATCH_SRC = 22;
  localparam int CFG_CAL_SRC = 20;
  localparam int CFG_RATE_FAM = 19;
  localparam logic [31:0] CFG_WR_MASK = 32'hEFD8_0000;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] PAIR_RESET = 32'h0000_0000;
  localparam int PAIR_UPPER_LO = 16;
  localparam int ST_CHAN_LO = 14;
  localparam int ST_GAIN_LO = 11;
  localparam int ST_WR_LO = 7;
  localparam int ST_POL = 6;
  localparam int ST_LATCH_LO = 4;
  localparam int ST_DELAY = 3;
  localparam int ST_OPEN_CUR = 2;
  localparam int ST_CALP_LO = 0;
  localparam logic [3:0] FN_WR_CFG = 4'h3;
  localparam logic [3:0] FN_WR_PAIR = 4'h5;
  localparam logic [3:0] FN_RD_CFG = 4'hB;
  localparam logic [3:0] FN_RD_PAIR = 4'hD;
  localparam logic [5:0] CMD_LAST = 6'h07;
  localparam logic [5:0] DATA_LAST = 6'h1F;
  localparam logic [10:0] PERIOD_STD = 11'h500;
  localparam logic [10:0] PERIOD_ALT = 11'h600;
  localparam logic [10:0] SETTLE_STD = 11'h500;
  localparam logic [10:0] SETTLE_ALT = 11'h600;
  localparam logic [2:0] GAIN_MAX = 3'h6;
  typedef enum logic [1:0] {P_CMD, P_WRITE, P_READ} acs_port_t;
  typedef enum logic [1:0] {C_IDLE, C_SETTLE, C_RUN} acs_conv_t;

  // Bit 4 marks a used code; bits 3:0 are the doublings of the fastest period
  function automatic logic [4:0] acs_rate_shift(input logic [3:0] code);
    case (code)
      4'h8: acs_rate_shift = 5'h10;
      4'h9: acs_rate_shift = 5'h11;
      4'hA: acs_rate_shift = 5'h12;
      4'hB: acs_rate_shift = 5'h13;
      4'hC: acs_rate_shift = 5'h14;
      4'h0: acs_rate_shift = 5'h15;
      4'h1: acs_rate_shift = 5'h16;
      4'h2: acs_rate_shift = 5'h17;
      4'h3: acs_rate_shift = 5'h18;
      4'h4: acs_rate_shift = 5'h19;
      default: acs_rate_shift = 5'h00;
    endcase
  endfunction
endpackage

// ### design/acs_divider.sv
// Master clock divider giving a one-cycle tick every period cycles
`timescale 1ns/1ps
module acs_divider
  import acs_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic run,
  input wire logic [19:0] period,
  output logic tick
);
  typedef struct packed {
    logic [19:0] cnt;
    logic tick;
  } acs_div_t;

  acs_div_t s_q;
  acs_div_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = 20'h0_0000;
    end else if (s_q.cnt == period - 20'h0_0001) begin
      s_d.cnt = 20'h0_0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 20'h0_0001;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule // acs_divider

// ### design/acs_serial.sv
// Serial command port pins: synchronisers, bit receive, word shift-out
`timescale 1ns/1ps
module acs_serial
  import acs_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  input wire logic [31:0] tx_word,
  input wire logic tx_load,
  output logic sdo_pin,
  output logic sdo_oe,
  output logic cs_active,
  output logic rx_valid,
  output logic rx_bit
);
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic ck_s1;
    logic ck_s2;
    logic ck_old;
    logic di_s1;
    logic di_s2;
    logic [31:0] tx;
    logic sdo;
  } acs_ser_t;

  acs_ser_t s_q;
  acs_ser_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.cs_s1 = cs_n_pin;
    s_d.cs_s2 = s_q.cs_s1;
    s_d.ck_s1 = sclk_pin;
    s_d.ck_s2 = s_q.ck_s1;
    s_d.ck_old = s_q.ck_s2;
    s_d.di_s1 = sdi_pin;
    s_d.di_s2 = s_q.di_s1;
    if (tx_load) begin
      s_d.tx = tx_word;
    end else if (!s_q.cs_s2 && s_q.ck_old && !s_q.ck_s2) begin
      // Data leaves on the falling edge so the host samples it on the rise
      s_d.sdo = s_q.tx[31];
      s_d.tx = {s_q.tx[30:0], 1'b0};
    end
    if (s_q.cs_s2) begin
      s_d.sdo = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{cs_s1: 1'b1, cs_s2: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign cs_active = !s_q.cs_s2;
  assign rx_valid = !s_q.cs_s2 && s_q.ck_s2 && !s_q.ck_old;
  assign rx_bit = s_q.di_s2;
  assign sdo_pin = s_q.sdo;
  assign sdo_oe = !s_q.cs_s2;
endmodule // acs_serial

// ### design/acs_regs.sv
// Configuration and setup pair registers, latch pins and word-rate control
`timescale 1ns/1ps
module acs_regs
  import acs_pkg::*;
#(
  parameter bit FOUR_CHANNEL = 1'b1
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  output logic sdo_pin,
  output logic sdo_oe,
  input wire logic [2:0] conv_setup_sel,
  input wire logic conv_start,
  input wire logic single_mode,
  output logic latch_a0,
  output logic latch_a0_en,
  output logic latch_a1,
  output logic guard_enable,
  output logic input_short,
  output logic ref_range_sel,
  output logic standby,
  output logic sleep,
  output logic osc_enable,
  output logic [3:0] sel_channel_hot,
  output logic sel_channel_bad,
  output logic [6:0] sel_gain_factor,
  output logic [2:0] span_div_log2,
  output logic sel_unipolar,
  output logic sel_open_current,
  output logic [1:0] sel_cal_index,
  output logic [19:0] word_period,
  output logic rate_valid,
  output logic settling,
  output logic converting,
  output logic word_tick,
  output logic result_ready,
  output logic reset_done_flag
);
  typedef struct packed {
    logic [31:0] cfg;
    logic [3:0][31:0] pair;
    acs_port_t pst;
    logic [7:0] cmd;
    logic [31:0] shr;
    logic [5:0] cnt;
    logic [31:0] tx;
    logic tx_load;
    acs_conv_t cst;
    logic [15:0] act;
    logic [1:0] latch;
    logic [19:0] period;
    logic rate_ok;
    logic first;
    logic result;
  } acs_state_t;

  acs_state_t s_q;
  acs_state_t s_d;

  logic cs_active;
  logic rx_valid;
  logic rx_bit;
  logic settle_tick;
  logic rate_tick;
  logic [7:0] cmd_next;
  logic [31:0] wdata;
  logic [15:0] sel_word;
  logic [4:0] rate_code;
  logic [10:0] base;
  logic [19:0] settle_len;
  logic exec;
  logic run_ok;

  acs_serial u_serial (
    .clock(clock),
    .resetn(resetn),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .sdi_pin(sdi_pin),
    .tx_word(s_q.tx),
    .tx_load(s_q.tx_load),
    .sdo_pin(sdo_pin),
    .sdo_oe(sdo_oe),
    .cs_active(cs_active),
    .rx_valid(rx_valid),
    .rx_bit(rx_bit)
  );

  // Settle wait before the first conversion of a delayed setup
  acs_divider u_settle (
    .clock(clock),
    .resetn(resetn),
    .run(s_q.cst == C_SETTLE),
    .period(settle_len),
    .tick(settle_tick)
  );

  // Word period counter, restarted whenever a new setup is taken
  acs_divider u_rate (
    .clock(clock),
    .resetn(resetn),
    .run(s_q.cst == C_RUN && s_q.rate_ok && !conv_start),
    .period(s_q.period),
    .tick(rate_tick)
  );

  assign cmd_next = {s_q.cmd[6:0], rx_bit};
  assign wdata = {s_q.shr[30:0], rx_bit};
  // The divider tick is registered, so count one short to settle for the full length
  assign settle_len = {9'h000, (s_q.cfg[CFG_RATE_FAM] ? SETTLE_ALT : SETTLE_STD) - 11'h001};
  assign run_ok = !s_q.cfg[CFG_PWR_DOWN] && !s_q.cfg[CFG_SYS_RST];

  // Setup 1 of a pair is the upper half, setup 2 the lower
  always_comb begin
    if (conv_setup_sel[0]) begin
      sel_word = s_q.pair[conv_setup_sel[2:1]][PAIR_UPPER_LO-1:0];
    end else begin
      sel_word = s_q.pair[conv_setup_sel[2:1]][31:PAIR_UPPER_LO];
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.tx_load = 1'b0;
    s_d.result = 1'b0;
    exec = 1'b0;
    rate_code = 5'h00;
    base = PERIOD_STD;

    // Serial command port
    if (!cs_active) begin
      s_d.pst = P_CMD;
      s_d.cnt = 6'h00;
    end else if (rx_valid) begin
      s_d.cnt = s_q.cnt + 6'h01;
      case (s_q.pst)
        P_CMD: begin
          s_d.cmd = cmd_next;
          if (s_q.cnt == CMD_LAST) begin
            s_d.cnt = 6'h00;
            case (cmd_next[3:0])
              FN_WR_CFG: begin
                s_d.pst = P_WRITE;
              end
              FN_WR_PAIR: begin
                s_d.pst = P_WRITE;
              end
              FN_RD_CFG: begin
                s_d.pst = P_READ;
                s_d.tx = s_q.cfg;
                s_d.tx_load = 1'b1;
              end
              FN_RD_PAIR: begin
                s_d.pst = P_READ;
                s_d.tx = s_q.pair[cmd_next[5:4]];
                s_d.tx_load = 1'b1;
              end
              default: begin
                s_d.pst = P_CMD;
              end
            endcase
          end
        end
        P_WRITE: begin
          s_d.shr = wdata;
          if (s_q.cnt == DATA_LAST) begin
            s_d.cnt = 6'h00;
            s_d.pst = P_CMD;
            exec = 1'b1;
            if (s_q.cmd[3:0] == FN_WR_PAIR) begin
              s_d.pair[s_q.cmd[5:4]] = wdata;
            end else if (s_q.cfg[CFG_SYS_RST]) begin
              // Leaving reset clears the bit only; other bits need another write
              s_d.cfg = CFG_RESET | (s_q.cfg & ~CFG_WR_MASK);
            end else if (wdata[CFG_SYS_RST]) begin
              s_d.cfg = CFG_RESET;
              s_d.cfg[CFG_SYS_RST] = 1'b1;
              s_d.pair = {4{PAIR_RESET}};
              s_d.act = 16'h0000;
              s_d.cst = C_IDLE;
              s_d.first = 1'b0;
            end else begin
              s_d.cfg = (wdata & CFG_WR_MASK) | (s_q.cfg & ~CFG_WR_MASK);
            end
          end
        end
        P_READ: begin
          if (s_q.cnt == DATA_LAST) begin
            s_d.cnt = 6'h00;
            s_d.pst = P_CMD;
            exec = 1'b1;
            if (s_q.cmd[3:0] == FN_RD_CFG) begin
              s_d.cfg[CFG_RST_DONE] = 1'b0;
            end
          end
        end
        default: begin
          s_d.pst = P_CMD;
        end
      endcase
    end

    // Set wins over the clear made by a read in the same cycle
    if (s_d.cfg[CFG_SYS_RST] && !s_q.cfg[CFG_SYS_RST]) begin
      s_d.cfg[CFG_RST_DONE] = 1'b1;
    end

    // Conversion sequencing
    case (s_q.cst)
      C_IDLE: begin
        s_d.first = 1'b0;
      end
      C_SETTLE: begin
        if (settle_tick) begin
          s_d.cst = C_RUN;
        end
      end
      C_RUN: begin
        if (rate_tick) begin
          if (s_q.first) begin
            s_d.first = 1'b0;
          end else begin
            s_d.result = 1'b1;
            if (single_mode) begin
              s_d.cst = C_IDLE;
            end
          end
        end
      end
      default: begin
        s_d.cst = C_IDLE;
      end
    endcase

    if (conv_start && run_ok) begin
      s_d.act = sel_word;
      s_d.first = 1'b1;
      s_d.cst = sel_word[ST_DELAY] ? C_SETTLE : C_RUN;
    end
    if (!run_ok) begin
      s_d.cst = C_IDLE;
    end

    // Word period from the active setup and the rate family
    rate_code = acs_rate_shift(s_d.act[ST_WR_LO+3:ST_WR_LO]);
    base = s_d.cfg[CFG_RATE_FAM] ? PERIOD_ALT : PERIOD_STD;
    s_d.rate_ok = rate_code[4];
    s_d.period = {9'h000, base} << rate_code[3:0];

    // Latch pins follow the chosen source on command execution or setup change
    if (exec || (conv_start && run_ok)) begin
      if (s_d.cfg[CFG_LATCH_SRC]) begin
        s_d.latch = s_d.cfg[CFG_LATCH_HI:CFG_LATCH_LO];
      end else begin
        s_d.latch = s_d.act[ST_LATCH_LO+1:ST_LATCH_LO];
      end
    end
    if (s_d.cfg[CFG_SYS_RST] && !s_q.cfg[CFG_SYS_RST]) begin
      s_d.latch = 2'h0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{pst: P_CMD, cst: C_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign latch_a0 = s_q.latch[1];
  assign latch_a1 = s_q.latch[0];
  assign latch_a0_en = !s_q.cfg[CFG_GUARD];
  assign guard_enable = s_q.cfg[CFG_GUARD];
  assign input_short = s_q.cfg[CFG_IN_SHORT];
  assign ref_range_sel = s_q.cfg[CFG_REF_RANGE];
  assign standby = s_q.cfg[CFG_PWR_DOWN] && !s_q.cfg[CFG_SAVE_SEL];
  assign sleep = s_q.cfg[CFG_PWR_DOWN] && s_q.cfg[CFG_SAVE_SEL];
  assign osc_enable = !sleep;
  assign reset_done_flag = s_q.cfg[CFG_RST_DONE];

  // Channel decode; channels 3 and 4 exist only on the four-channel build
  always_comb begin
    sel_channel_hot = 4'h1 << s_q.act[ST_CHAN_LO+1:ST_CHAN_LO];
    sel_channel_bad = !FOUR_CHANNEL && s_q.act[ST_CHAN_LO+1];
  end

  // Gain 2^code, zero above code 6; span divides by the gain alone, span_div_log2 is the gain code
  always_comb begin
    sel_gain_factor = 7'h01 << s_q.act[ST_GAIN_LO+2:ST_GAIN_LO];
    if (s_q.act[ST_GAIN_LO+2:ST_GAIN_LO] > GAIN_MAX) begin
      sel_gain_factor = 7'h00;
    end
    span_div_log2 = s_q.act[ST_GAIN_LO+2:ST_GAIN_LO];
  end

  // Calibration register pair comes from channel or pointer field
  always_comb begin
    if (s_q.cfg[CFG_CAL_SRC]) begin
      sel_cal_index = s_q.act[ST_CALP_LO+1:ST_CALP_LO];
    end else begin
      sel_cal_index = s_q.act[ST_CHAN_LO+1:ST_CHAN_LO];
    end
  end

  assign sel_unipolar = s_q.act[ST_POL];
  assign sel_open_current = s_q.act[ST_OPEN_CUR];
  assign word_period = s_q.period;
  assign rate_valid = s_q.rate_ok;
  assign settling = s_q.cst == C_SETTLE;
  assign converting = s_q.cst == C_RUN;
  assign word_tick = rate_tick;
  assign result_ready = s_q.result;
endmodule // acs_regs

// ### test/acs_regs_checker.sv
// Port-level assertions for the converter register bank
`timescale 1ns/1ps
module acs_regs_checker
  import acs_pkg::*;
#(
  parameter bit FOUR_CHANNEL = 1'b1
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic cs_n_pin,
  input wire logic sdo_pin,
  input wire logic sdo_oe,
  input wire logic conv_start,
  input wire logic latch_a0_en,
  input wire logic guard_enable,
  input wire logic standby,
  input wire logic sleep,
  input wire logic osc_enable,
  input wire logic [3:0] sel_channel_hot,
  input wire logic sel_channel_bad,
  input wire logic [6:0] sel_gain_factor,
  input wire logic [2:0] span_div_log2,
  input wire logic settling,
  input wire logic converting,
  input wire logic word_tick,
  input wire logic result_ready
);
  logic [11:0] settle_cnt_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Length of the current settling stretch
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle_cnt_q <= 12'h000;
    end else if (settling) begin
      settle_cnt_q <= settle_cnt_q + 12'h001;
    end else begin
      settle_cnt_q <= 12'h000;
    end
  end
  property p_power_mode;
    !(standby && sleep) && (osc_enable == !sleep);
  endproperty
  a_power_mode: assert property (p_power_mode)
    else $error("power mode outputs inconsistent");
  property p_refuse_pd;
    conv_start && (standby || sleep) && !settling && !converting |=> !settling && !converting;
  endproperty
  a_refuse_pd: assert property (p_refuse_pd)
    else $error("conversion started while powered down");
  property p_guard;
    guard_enable [*2] |-> !latch_a0_en;
  endproperty
  a_guard: assert property (p_guard)
    else $error("first latch pin still driven under guard");
  property p_chan;
    $onehot(sel_channel_hot) && !(FOUR_CHANNEL && sel_channel_bad);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel select decode wrong");
  property p_gain;
    sel_gain_factor == ((span_div_log2 == 3'h7) ? 7'h00 : (7'h01 << span_div_log2));
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain factor not a power of two of the code");
  property p_settle;
    $fell(settling) && converting |-> (settle_cnt_q == 12'h500) || (settle_cnt_q == 12'h600);
  endproperty
  a_settle: assert property (p_settle)
    else $error("settling stretch has wrong length");
  property p_sdo_idle;
    cs_n_pin [*5] |-> !sdo_oe && !sdo_pin;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("data out active while port deselected");
  property p_tick_gap;
    word_tick |=> !word_tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("word ticks too close together");
  property p_first_late;
    $rose(converting) |-> !result_ready [*8];
  endproperty
  a_first_late: assert property (p_first_late)
    else $error("result too soon after start");
endmodule // acs_regs_checker

bind acs_regs acs_regs_checker #(.FOUR_CHANNEL(FOUR_CHANNEL)) i_acs_chk (
  .clock, .resetn, .cs_n_pin, .sdo_pin, .sdo_oe, .conv_start, .latch_a0_en,
  .guard_enable, .standby, .sleep, .osc_enable, .sel_channel_hot, .sel_channel_bad,
  .sel_gain_factor, .span_div_log2, .settling, .converting, .word_tick, .result_ready
);

// ### test/acs_host.sv
// Host model driving the serial command port
`timescale 1ns/1ps
module acs_host (
  input wire logic clock,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic sdi_pin,
  input wire logic sdo_pin
);
  logic idle = 1'b1;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    sdi_pin = 1'b0;
  end
  // Released data line wanders so a stale level never passes for data
  always @(negedge clock) begin
    if (idle) begin
      sdi_pin <= ~sdi_pin;
    end
  end
  // Command byte then a whole 32-bit word, MSB first
  task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd, output logic [31:0] rd);
    logic [39:0] sh;
    sh = {cmd, wd};
    rd = 32'h0000_0000;
    idle = 1'b0;
    @(negedge clock);
    cs_n_pin = 1'b0;
    for (int i = 39; i >= 0; i--) begin
      sdi_pin = sh[i];
      repeat (6) @(negedge clock);
      if (i < 32) rd[i] = sdo_pin;
      sclk_pin = 1'b1;
      repeat (6) @(negedge clock);
      sclk_pin = 1'b0;
    end
    repeat (6) @(negedge clock);
    cs_n_pin = 1'b1;
    idle = 1'b1;
    repeat (6) @(negedge clock);
  endtask
endmodule // acs_host

// ### test/testbench.sv
// Self-checking bench for the converter register bank
`timescale 1ns/1ps
module testbench
  import acs_pkg::*;
;
  typedef struct {string name; logic [31:0] val;} acs_note_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cs_n_pin, sclk_pin, sdi_pin, sdo_pin, sdo_oe, conv_start, single_mode;
  logic [2:0] conv_setup_sel;
  logic latch_a0, latch_a0_en, latch_a1, guard_enable, input_short, ref_range_sel;
  logic standby, sleep, osc_enable, sel_channel_bad, sel_unipolar, sel_open_current;
  logic [3:0] sel_channel_hot;
  logic [6:0] sel_gain_factor;
  logic [2:0] span_div_log2;
  logic [1:0] sel_cal_index;
  logic [19:0] word_period;
  logic rate_valid, settling, converting, word_tick, result_ready, reset_done_flag;
  logic [31:0] rd;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int gap = 0;
  acs_note_t notes[$];
  event look;
  initial forever #10 clock = ~clock;
  acs_host i_host (.clock, .cs_n_pin, .sclk_pin, .sdi_pin, .sdo_pin);
  acs_regs #(.FOUR_CHANNEL(1'b1)) i_dut (
    .clock, .resetn, .cs_n_pin, .sclk_pin, .sdi_pin, .sdo_pin, .sdo_oe, .conv_setup_sel,
    .conv_start, .single_mode, .latch_a0, .latch_a0_en, .latch_a1, .guard_enable,
    .input_short, .ref_range_sel, .standby, .sleep, .osc_enable, .sel_channel_hot,
    .sel_channel_bad, .sel_gain_factor, .span_div_log2, .sel_unipolar, .sel_open_current,
    .sel_cal_index, .word_period, .rate_valid, .settling, .converting, .word_tick,
    .result_ready, .reset_done_flag
  );
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [31:0] sense(input string name);
    case (name)
      "rd": sense = rd;
      "latch": sense = {30'h0000_0000, latch_a0, latch_a1};
      "power": sense = {25'h000_0000, standby, sleep, osc_enable, input_short, guard_enable,
                        latch_a0_en, ref_range_sel};
      "setup": sense = {16'h0000, sel_channel_hot, sel_gain_factor, sel_cal_index,
                        sel_unipolar, sel_open_current, rate_valid};
      "run": sense = {30'h0000_0000, settling, converting};
      "period": sense = {12'h000, word_period};
      "done": sense = {31'h0000_0000, reset_done_flag};
      "gap": sense = {31'h0000_0000, gap > 1280 && gap < 8000};
      "count": sense = 32'(gap);
      default: sense = 32'h0000_0000;
    endcase
  endfunction
  // Watcher takes the oldest note and compares it with the live outputs
  initial begin : watch
    acs_note_t n;
    forever begin
      @(look);
      n = notes.pop_front();
      check(n.name, sense(n.name), n.val);
    end
  end
  task automatic note(input string name, input logic [31:0] val);
    notes.push_back('{name, val});
    -> look;
    #1;
  endtask
  task automatic wcfg(input logic [31:0] d);
    i_host.xfer({4'h0, FN_WR_CFG}, d, rd);
  endtask
  task automatic rcfg(input logic [31:0] e);
    i_host.xfer({4'h0, FN_RD_CFG}, 32'h0000_0000, rd);
    note("rd", e);
  endtask
  task automatic start(input logic [2:0] sel);
    @(negedge clock);
    conv_setup_sel = sel;
    conv_start = 1'b1;
    @(negedge clock);
    conv_start = 1'b0;
    @(negedge clock);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 12000 && (settling || converting); n++) @(negedge clock);
    note("run", 32'h0000_0000);
  endtask
  initial begin : main
    logic [31:0] d;
    conv_setup_sel = 3'h0;
    conv_start = 1'b0;
    single_mode = 1'b1;
    void'($urandom(32'h297c));
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    rcfg(32'h0000_0000);
    note("latch", 32'h0000_0000);
    note("power", 32'h0000_0012);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      d = $urandom() & ~32'h2780_2780;
      i_host.xfer({2'b00, 2'(i), FN_WR_PAIR}, d, rd);
      i_host.xfer({2'b00, 2'(i), FN_RD_PAIR}, 32'h0000_0000, rd);
      note("rd", d);
    end
    $display("test pairs done");
    i_host.xfer({4'h0, FN_WR_PAIR}, 32'h742B_8455, rd);
    start(3'h0);
    note("setup", {16'h0000, 4'h2, 7'h40, 2'h1, 3'h1});
    note("run", 32'h0000_0002);
    note("latch", 32'h0000_0002);
    note("period", 32'h0000_0500);
    wait_idle();
    start(3'h1);
    note("setup", {16'h0000, 4'h4, 7'h01, 2'h2, 3'h7});
    note("latch", 32'h0000_0001);
    while (!result_ready && gap < 8000) begin
      @(negedge clock);
      gap++;
    end
    note("gap", 32'h0000_0001);
    wait_idle();
    note("run", 32'h0000_0000);
    $display("test convert done");
    wcfg(32'h0018_0000);
    start(3'h0);
    note("setup", {16'h0000, 4'h2, 7'h40, 2'h3, 3'h1});
    note("period", 32'h0000_0600);
    wait_idle();
    for (int c = 0; c < 4; c++) begin
      wcfg(32'h0040_0000 | (32'(c) << 23));
      note("latch", 32'(c));
    end
    single_mode = 1'b0;
    start(3'h1);
    note("latch", 32'h0000_0003);
    // Continuous mode: the second result follows the first by one word period
    for (int k = 0; k < 2; k++) begin
      gap = 0;
      do begin
        @(negedge clock);
        gap++;
      end while (!result_ready && gap < 8000);
    end
    note("count", 32'h0000_0500);
    note("run", 32'h0000_0001);
    $display("test latch done");
    wcfg(32'h2000_0000 | ($urandom() & CFG_WR_MASK));
    note("latch", 32'h0000_0000);
    note("done", 32'h0000_0001);
    note("run", 32'h0000_0000);
    rcfg(32'h3000_0000);
    rcfg(32'h2000_0000);
    note("done", 32'h0000_0000);
    i_host.xfer({4'h0, FN_RD_PAIR}, 32'h0000_0000, rd);
    note("rd", 32'h0000_0000);
    wcfg(32'h0000_0000);
    rcfg(32'h0000_0000);
    $display("test soft reset done");
    wcfg(32'h4E00_0000);
    note("power", 32'h0000_005D);
    start(3'h1);
    note("run", 32'h0000_0000);
    wcfg(32'hCE00_0000);
    note("power", 32'h0000_002D);
    $display("test power done");
    end_of_test();
  end
endmodule // testbench
